// ---- src/dct_pkg.sv ----
package dct_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TICK_DIV = 12;
    localparam logic [3:0] PRE_LAST = 4'(TICK_DIV - 1);

    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_MODE = 8'h04;
    localparam logic [7:0] ADDR_PRESC = 8'h08;
    localparam logic [7:0] ADDR_T0LO = 8'h0c;
    localparam logic [7:0] ADDR_T0HI = 8'h10;
    localparam logic [7:0] ADDR_T1LO = 8'h14;
    localparam logic [7:0] ADDR_T1HI = 8'h18;
    localparam logic [7:0] ADDR_ISTAT = 8'h1c;
    localparam logic [7:0] ADDR_IMASK = 8'h20;

    localparam int unsigned CTRL_RUN0 = 4;
    localparam int unsigned CTRL_OVF0 = 5;
    localparam int unsigned CTRL_STEP = 2;
    localparam logic [7:0] CTRL_MASK = 8'hf0;
    localparam int unsigned MODE_FIELD_W = 4;
    localparam int unsigned MODE_SEL = 0;
    localparam int unsigned MODE_SRC = 2;
    localparam int unsigned MODE_GATE = 3;
    localparam logic [7:0] PRESC_MASK = 8'h03;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_13BIT,
        MODE_16BIT,
        MODE_RELOAD8,
        MODE_SPLIT
    } dct_mode_e;

    typedef struct packed {
        logic run;
        logic gate;
        logic srcExt;
        logic fast;
        dct_mode_e mode;
    } dct_cfg_s;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } dct_count_s;

    typedef struct packed {
        logic wrLow;
        logic wrHigh;
        logic [7:0] data;
    } dct_wr_s;
endpackage : dct_pkg

// ---- src/dct_timer.sv ----
`timescale 1ns/100ps
module dct_timer (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire dct_pkg::dct_cfg_s cfg,
    input wire logic tick,
    input wire logic evEdge,
    input wire logic gateLevel,
    input wire dct_pkg::dct_wr_s wr,
    output dct_pkg::dct_count_s count,
    output logic ovf
);
    dct_pkg::dct_count_s q;
    dct_pkg::dct_count_s n;
    logic en;
    logic anyWr;
    logic [12:0] c13;
    logic [15:0] c16;
    logic [7:0] c8;

    assign en = cfg.run && (!cfg.gate || gateLevel)
        && (cfg.srcExt ? evEdge : tick);
    assign anyWr = wr.wrLow || wr.wrHigh;
    assign count = q;

    always_comb begin
        n = q;
        ovf = 1'b0;
        c13 = {q.high, q.low[4:0]} + 13'h1;
        c16 = {q.high, q.low} + 16'h1;
        c8 = q.low + 8'h1;
        if (en) begin
            case (cfg.mode)
                dct_pkg::MODE_13BIT: begin
                    // Upper three low bits left alone
                    n.high = c13[12:5];
                    n.low[4:0] = c13[4:0];
                    ovf = (c13 == 13'h0000);
                end
                dct_pkg::MODE_16BIT: begin
                    {n.high, n.low} = c16;
                    ovf = (c16 == 16'h0000);
                end
                dct_pkg::MODE_RELOAD8: begin
                    ovf = (c8 == 8'h00);
                    n.low = ovf ? q.high : c8;
                end
                default: begin
                    // Split mode not built; counter holds
                end
            endcase
        end
        // Software load wins over counting; run does not clear
        if (wr.wrLow) begin
            n.low = wr.data;
        end
        if (wr.wrHigh) begin
            n.high = wr.data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    property p_hold;
        !en && !anyWr |=> count == $past(count);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved while off");

    property p_wrap13;
        en && !anyWr && cfg.mode == dct_pkg::MODE_13BIT
            && q.high == 8'hff && q.low[4:0] == 5'h1f
            |-> ovf ##1 (q.high == 8'h00 && q.low[4:0] == 5'h00);
    endproperty
    a_wrap13: assert property (p_wrap13) else $error("13-bit wrap wrong");

    property p_carry13;
        en && !anyWr && cfg.mode == dct_pkg::MODE_13BIT
            && q.low[4:0] == 5'h1f
            |=> q.high == $past(q.high) + 8'h01
            && q.low[7:5] == $past(q.low[7:5]);
    endproperty
    a_carry13: assert property (p_carry13) else $error("13-bit carry wrong");

    property p_count16;
        en && !anyWr && cfg.mode == dct_pkg::MODE_16BIT
            |=> {q.high, q.low} == $past({q.high, q.low}) + 16'h1;
    endproperty
    a_count16: assert property (p_count16) else $error("16-bit step wrong");

    sequence s_reloadFire;
        en && !anyWr && cfg.mode == dct_pkg::MODE_RELOAD8 && q.low == 8'hff;
    endsequence
    property p_reload;
        s_reloadFire |-> ovf ##1
            (q.low == $past(q.high) && q.high == $past(q.high));
    endproperty
    a_reload: assert property (p_reload) else $error("reload wrong");

    property p_runKeep;
        $rose(cfg.run) && !$past(anyWr) |-> count == $past(count);
    endproperty
    a_runKeep: assert property (p_runKeep) else $error("run cleared count");

    property p_ovfCause;
        ovf |-> en && cfg.mode != dct_pkg::MODE_SPLIT;
    endproperty
    a_ovfCause: assert property (p_ovfCause) else $error("stray overflow");
endmodule : dct_timer

// ---- src/dct_top.sv ----
`timescale 1ns/100ps
module dct_top (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic eventInputZero,
    input wire logic eventInputOne,
    input wire logic externalGateInputZero,
    input wire logic externalGateInputOne,
    output logic irq
);
    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [1:0] prevEv;
        logic [3:0] pre;
        logic [7:0] ctrl;
        logic [7:0] modeReg;
        logic [7:0] presc;
        logic [1:0] iStat;
        logic [1:0] iMask;
        logic awPend;
        logic [7:0] awAddr;
        logic wPend;
        logic [7:0] wData;
        logic wStrb0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic irq;
    } dct_state_s;

    dct_state_s q;
    dct_state_s n;
    logic tick12;
    logic doWrite;
    logic [1:0] evFall;
    logic [1:0] ovf;
    logic [7:0] rByte;
    dct_pkg::dct_cfg_s cfg [2];
    dct_pkg::dct_wr_s wr [2];
    dct_pkg::dct_count_s cnt [2];

    assign tick12 = (q.pre == dct_pkg::PRE_LAST);
    // Second stage against its own delayed copy
    assign evFall = q.prevEv & ~q.s2[1:0];
    assign doWrite = q.awPend && q.wPend && !q.bvalid;

    for (genvar i = 0; i < 2; i++) begin : g_tmr
        localparam int unsigned MB = i * dct_pkg::MODE_FIELD_W;
        localparam int unsigned RB = dct_pkg::CTRL_RUN0 + i * dct_pkg::CTRL_STEP;
        localparam logic [7:0] LO = i ? dct_pkg::ADDR_T1LO : dct_pkg::ADDR_T0LO;
        localparam logic [7:0] HI = i ? dct_pkg::ADDR_T1HI : dct_pkg::ADDR_T0HI;

        assign cfg[i] = {q.ctrl[RB],
            q.modeReg[MB + dct_pkg::MODE_GATE],
            q.modeReg[MB + dct_pkg::MODE_SRC],
            q.presc[i],
            dct_pkg::dct_mode_e'(q.modeReg[MB + dct_pkg::MODE_SEL +: 2])};
        assign wr[i] = {doWrite && q.wStrb0 && q.awAddr == LO,
            doWrite && q.wStrb0 && q.awAddr == HI, q.wData};

        dct_timer u_tmr (
            .sys_clk(sys_clk),
            .nrst(nrst),
            .cfg(cfg[i]),
            .tick(q.presc[i] | tick12),
            .evEdge(evFall[i]),
            .gateLevel(q.s2[2 + i]),
            .wr(wr[i]),
            .count(cnt[i]),
            .ovf(ovf[i])
        );
    end

    always_comb begin
        case (araddr)
            dct_pkg::ADDR_CTRL: rByte = q.ctrl;
            dct_pkg::ADDR_MODE: rByte = q.modeReg;
            dct_pkg::ADDR_PRESC: rByte = q.presc;
            dct_pkg::ADDR_T0LO: rByte = cnt[0].low;
            dct_pkg::ADDR_T0HI: rByte = cnt[0].high;
            dct_pkg::ADDR_T1LO: rByte = cnt[1].low;
            dct_pkg::ADDR_T1HI: rByte = cnt[1].high;
            dct_pkg::ADDR_ISTAT: rByte = {6'h00, q.iStat};
            dct_pkg::ADDR_IMASK: rByte = {6'h00, q.iMask};
            default: rByte = dct_pkg::RST_BYTE;
        endcase
    end

    always_comb begin
        n = q;
        // Pins pass two flops before any use
        n.s1 = {externalGateInputOne, externalGateInputZero,
            eventInputOne, eventInputZero};
        n.s2 = q.s1;
        n.prevEv = q.s2[1:0];
        n.pre = tick12 ? 4'h0 : q.pre + 4'h1;

        if (awvalid && q.awready) begin
            n.awPend = 1'b1;
            n.awAddr = awaddr;
        end
        if (wvalid && q.wready) begin
            n.wPend = 1'b1;
            n.wData = wdata[7:0];
            n.wStrb0 = wstrb[0];
        end
        if (q.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        if (doWrite) begin
            n.awPend = 1'b0;
            n.wPend = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = dct_pkg::RESP_OKAY;
            case (q.awAddr)
                dct_pkg::ADDR_CTRL: begin
                    if (q.wStrb0) begin
                        n.ctrl = q.wData & dct_pkg::CTRL_MASK;
                    end
                end
                dct_pkg::ADDR_MODE: begin
                    if (q.wStrb0) begin
                        n.modeReg = q.wData;
                    end
                end
                dct_pkg::ADDR_PRESC: begin
                    if (q.wStrb0) begin
                        n.presc = q.wData & dct_pkg::PRESC_MASK;
                    end
                end
                dct_pkg::ADDR_ISTAT: begin
                    if (q.wStrb0) begin
                        n.iStat = q.iStat & ~q.wData[1:0];
                    end
                end
                dct_pkg::ADDR_IMASK: begin
                    if (q.wStrb0) begin
                        n.iMask = q.wData[1:0];
                    end
                end
                dct_pkg::ADDR_T0LO, dct_pkg::ADDR_T0HI,
                dct_pkg::ADDR_T1LO, dct_pkg::ADDR_T1HI: begin
                    n.bresp = dct_pkg::RESP_OKAY;
                end
                default: begin
                    n.bresp = dct_pkg::RESP_SLVERR;
                end
            endcase
        end
        // Overflow sets win over a clearing write
        for (int i = 0; i < 2; i++) begin
            if (ovf[i]) begin
                n.ctrl[dct_pkg::CTRL_OVF0 + i * dct_pkg::CTRL_STEP] = 1'b1;
                n.iStat[i] = 1'b1;
            end
        end

        if (q.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
        if (arvalid && q.arready) begin
            n.rvalid = 1'b1;
            n.rdata = {24'h000000, rByte};
            n.rresp = dct_pkg::RESP_OKAY;
            case (araddr)
                dct_pkg::ADDR_CTRL, dct_pkg::ADDR_MODE, dct_pkg::ADDR_PRESC,
                dct_pkg::ADDR_T0LO, dct_pkg::ADDR_T0HI, dct_pkg::ADDR_T1LO,
                dct_pkg::ADDR_T1HI, dct_pkg::ADDR_ISTAT,
                dct_pkg::ADDR_IMASK: n.rresp = dct_pkg::RESP_OKAY;
                default: n.rresp = dct_pkg::RESP_SLVERR;
            endcase
        end

        n.awready = !n.awPend && !n.bvalid;
        n.wready = !n.wPend && !n.bvalid;
        n.arready = !n.rvalid;
        n.irq = |(n.iStat & n.iMask);
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign awready = q.awready;
    assign wready = q.wready;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = q.arready;
    assign rvalid = q.rvalid;
    assign rdata = q.rdata;
    assign rresp = q.rresp;
    assign irq = q.irq;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence s_quiet8;
        (!tick12) [*8];
    endsequence
    property p_tickSpacing;
        tick12 |-> ##1 s_quiet8 ##1 !tick12 ##1 !tick12 ##1 !tick12 ##1 tick12;
    endproperty
    a_tickSpacing: assert property (p_tickSpacing) else $error("tick spacing wrong");

    property p_evEdge;
        evFall[0] |-> $past(eventInputZero, 3) && !$past(eventInputZero, 2) ##1 !evFall[0];
    endproperty
    a_evEdge: assert property (p_evEdge) else $error("edge pulse wrong");

    property p_flagSet;
        ovf[1] |=> q.ctrl[dct_pkg::CTRL_OVF0 + dct_pkg::CTRL_STEP] && q.iStat[1];
    endproperty
    a_flagSet: assert property (p_flagSet) else $error("flag not set");

    property p_irq;
        ovf[0] && q.iMask[0] |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("no interrupt");
endmodule : dct_top

// ---- verification/dct_pin_model.sv ----
`timescale 1ns/100ps
module dct_pin_model (
    input wire logic sys_clk,
    output logic eventInputZero,
    output logic eventInputOne
);
    initial begin
        eventInputZero = 1'b1;
        eventInputOne = 1'b1;
    end

    // Falling edges on one event pin, low kept three clocks, high at least three
    task automatic pulse(input int which, input int n);
        repeat (n) begin
            @(posedge sys_clk);
            if (which == 0) begin
                eventInputZero <= 1'b0;
            end else begin
                eventInputOne <= 1'b0;
            end
            repeat (3) @(posedge sys_clk);
            eventInputZero <= 1'b1;
            eventInputOne <= 1'b1;
            repeat (3) @(posedge sys_clk);
        end
        // Let the synchroniser and count stages settle
        repeat (4) @(posedge sys_clk);
    endtask : pulse
endmodule : dct_pin_model

// ---- verification/dct_top_tb.sv ----
`timescale 1ns/100ps
module dct_top_tb;
    logic sys_clk;
    logic nrst;
    logic [7:0] awaddr;
    logic awvalid;
    logic awready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready;
    logic eventInputZero;
    logic eventInputOne;
    logic gateZero;
    logic gateOne;
    logic irq;
    logic [31:0] rword;
    logic [7:0] lo;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;

    dct_top dct_top_i (.sys_clk(sys_clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .eventInputZero(eventInputZero), .eventInputOne(eventInputOne),
        .externalGateInputZero(gateZero), .externalGateInputOne(gateOne), .irq(irq));

    dct_pin_model dct_pin_model_i (.sys_clk(sys_clk), .eventInputZero(eventInputZero),
        .eventInputOne(eventInputOne));

    initial begin
        sys_clk = 1'b0;
        forever #(dct_pkg::CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
    end

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d,
            input logic [1:0] er = dct_pkg::RESP_OKAY);
        logic awDone;
        logic wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (!awDone && awready) begin
                awDone = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wDone && wready) begin
                wDone = 1'b1;
                wvalid <= 1'b0;
            end
        end while (!(awDone && wDone && bvalid));
        bready <= 1'b0;
        check($sformatf("write resp %h", a), {32'h00000000, bresp}, {32'h00000000, er});
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff,
            input logic [1:0] er = dct_pkg::RESP_OKAY);
        logic done;
        done = 1'b0;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (!done && arready) begin
                done = 1'b1;
                arvalid <= 1'b0;
            end
        end while (!(done && rvalid));
        rword = rdata;
        rready <= 1'b0;
        check($sformatf("read %h", a), {rresp, rdata & {24'hffffff, m}},
            {er, 24'h000000, e});
    endtask : rc

    task automatic irqIs(input logic e);
        @(posedge sys_clk);
        check("irq", {33'h000000000, irq}, {33'h000000000, e});
    endtask : irqIs

    initial begin
        nrst = 1'b0;
        awaddr = 8'h00;
        awvalid = 1'b0;
        wdata = 32'h00000000;
        wstrb = 4'h0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 8'h00;
        arvalid = 1'b0;
        rready = 1'b0;
        gateZero = 1'b0;
        gateOne = 1'b0;
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        for (int a = 0; a <= 32; a += 4) begin
            rc(8'(a), 8'h00);
        end
        wr(8'h24, 8'h5a, dct_pkg::RESP_SLVERR);
        rc(8'h24, 8'h00, 8'hff, dct_pkg::RESP_SLVERR);
        // Timer zero, 13-bit, pin source, preset two counts below wrap
        wr(dct_pkg::ADDR_MODE, 8'h04);
        wr(dct_pkg::ADDR_T0HI, 8'hff);
        wr(dct_pkg::ADDR_T0LO, 8'h1e);
        wr(dct_pkg::ADDR_IMASK, 8'h01);
        wr(dct_pkg::ADDR_CTRL, 8'h10);
        rc(dct_pkg::ADDR_T0LO, 8'h1e);
        dct_pin_model_i.pulse(0, 1);
        rc(dct_pkg::ADDR_T0LO, 8'h1f, 8'h1f);
        rc(dct_pkg::ADDR_T0HI, 8'hff);
        rc(dct_pkg::ADDR_CTRL, 8'h10);
        dct_pin_model_i.pulse(0, 1);
        rc(dct_pkg::ADDR_T0LO, 8'h00, 8'h1f);
        rc(dct_pkg::ADDR_T0HI, 8'h00);
        rc(dct_pkg::ADDR_CTRL, 8'h30);
        rc(dct_pkg::ADDR_ISTAT, 8'h01);
        irqIs(1'b1);
        wr(dct_pkg::ADDR_IMASK, 8'h02);
        irqIs(1'b0);
        wr(dct_pkg::ADDR_IMASK, 8'h03);
        irqIs(1'b1);
        wr(dct_pkg::ADDR_ISTAT, 8'h01);
        irqIs(1'b0);
        rc(dct_pkg::ADDR_ISTAT, 8'h00);
        wr(dct_pkg::ADDR_CTRL, 8'h10);
        rc(dct_pkg::ADDR_CTRL, 8'h10);
        // Timer one, 16-bit, pin source
        wr(dct_pkg::ADDR_MODE, 8'h54);
        wr(dct_pkg::ADDR_T1LO, 8'hff);
        wr(dct_pkg::ADDR_T1HI, 8'h12);
        wr(dct_pkg::ADDR_CTRL, 8'h50);
        dct_pin_model_i.pulse(1, 1);
        rc(dct_pkg::ADDR_T1LO, 8'h00);
        rc(dct_pkg::ADDR_T1HI, 8'h13);
        rc(dct_pkg::ADDR_T0LO, 8'h00, 8'h1f);
        wr(dct_pkg::ADDR_T1HI, 8'hff);
        wr(dct_pkg::ADDR_T1LO, 8'hff);
        dct_pin_model_i.pulse(1, 1);
        rc(dct_pkg::ADDR_T1HI, 8'h00);
        rc(dct_pkg::ADDR_CTRL, 8'hd0);
        rc(dct_pkg::ADDR_ISTAT, 8'h02);
        irqIs(1'b1);
        wr(dct_pkg::ADDR_ISTAT, 8'h03);
        wr(dct_pkg::ADDR_CTRL, 8'h00);
        // Timer zero auto-reload
        wr(dct_pkg::ADDR_MODE, 8'h56);
        wr(dct_pkg::ADDR_T0HI, 8'ha5);
        wr(dct_pkg::ADDR_T0LO, 8'hfe);
        wr(dct_pkg::ADDR_CTRL, 8'h10);
        dct_pin_model_i.pulse(0, 2);
        rc(dct_pkg::ADDR_T0LO, 8'ha5);
        rc(dct_pkg::ADDR_T0HI, 8'ha5);
        rc(dct_pkg::ADDR_CTRL, 8'h30);
        dct_pin_model_i.pulse(0, 1);
        rc(dct_pkg::ADDR_T0LO, 8'ha6);
        // Both timers 16-bit, pin source, gated
        wr(dct_pkg::ADDR_MODE, 8'hdd);
        wr(dct_pkg::ADDR_CTRL, 8'h50);
        for (int i = 0; i < 2; i++) begin
            lo = 8'(dct_pkg::ADDR_T0LO + 8 * i);
            wr(lo, 8'h00);
            dct_pin_model_i.pulse(i, 1);
            rc(lo, 8'h00);
            @(posedge sys_clk);
            if (i == 0) begin
                gateZero <= 1'b1;
            end else begin
                gateOne <= 1'b1;
            end
            repeat (3) @(posedge sys_clk);
            dct_pin_model_i.pulse(i, 1);
            rc(lo, 8'h01);
        end
        wr(dct_pkg::ADDR_CTRL, 8'h00);
        dct_pin_model_i.pulse(0, 1);
        rc(dct_pkg::ADDR_T0LO, 8'h01);
        // Timer zero held in the unbuilt mode, timer one reloads
        wr(dct_pkg::ADDR_T1HI, 8'h80);
        wr(dct_pkg::ADDR_T1LO, 8'hff);
        wr(dct_pkg::ADDR_MODE, 8'h67);
        wr(dct_pkg::ADDR_CTRL, 8'h50);
        dct_pin_model_i.pulse(0, 1);
        dct_pin_model_i.pulse(1, 1);
        rc(dct_pkg::ADDR_T0LO, 8'h01);
        rc(dct_pkg::ADDR_T1LO, 8'h80);
        rc(dct_pkg::ADDR_T1HI, 8'h80);
        rc(dct_pkg::ADDR_CTRL, 8'hd0);
        wr(dct_pkg::ADDR_CTRL, 8'h00);
        // Tick rate, divide by twelve then by one
        wr(dct_pkg::ADDR_MODE, 8'h01);
        for (int f = 0; f < 2; f++) begin
            wr(dct_pkg::ADDR_PRESC, 8'(f));
            wr(dct_pkg::ADDR_T0LO, 8'h00);
            wr(dct_pkg::ADDR_CTRL, 8'h10);
            repeat (240) @(posedge sys_clk);
            wr(dct_pkg::ADDR_CTRL, 8'h00);
            rc(dct_pkg::ADDR_T0LO, 8'h00, 8'h00);
            lo = rword[7:0];
            if (f == 0) begin
                check("slow ticks", {33'h0, lo >= 8'd19 && lo <= 8'd22}, 34'h1);
            end else begin
                check("fast ticks", {33'h0, lo >= 8'd238 && lo <= 8'd248}, 34'h1);
            end
        end
        wrap_up();
    end
endmodule : dct_top_tb
